// File: bench/host_model.sv
// host processor model driving the uart register bus
`timescale 1ns/1ps
module host_model (
	input wire logic core_clk, // bus clock
	input wire logic [7:0] data_out, // read data from the device
	input wire logic data_oe_n, // device read drive, active low
	output logic [1:0] channel_select_n, // channel selects, active low
	output logic [2:0] addr, // register offset
	output logic host_wr_n, // write strobe, active low
	output logic host_rd_n, // read strobe, active low
	output logic [7:0] data_in // write data
);
	logic [7:0] saved_fmt; // line format kept across a view switch
	// idle bus: nothing selected, strobes high
	initial begin
		channel_select_n = 2'h3;
		addr = 3'h0;
		host_wr_n = 1'b1;
		host_rd_n = 1'b1;
		data_in = 8'h00;
		saved_fmt = 8'h00;
	end
	// one write; data scrambled once released so stale bytes never match
	task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
		@(negedge core_clk);
		channel_select_n = ch ? 2'h1 : 2'h2;
		addr = a;
		data_in = d;
		host_wr_n = 1'b0;
		@(negedge core_clk);
		host_wr_n = 1'b1;
		channel_select_n = 2'h3;
		data_in = ~d;
		@(negedge core_clk);
	endtask
	// one read; drive flag sampled during the answer and after release
	task automatic rd(input logic ch, input logic [2:0] a, output logic [7:0] d, output logic on, output logic off);
		@(negedge core_clk);
		channel_select_n = ch ? 2'h1 : 2'h2;
		addr = a;
		host_rd_n = 1'b0;
		@(negedge core_clk);
		d = data_out;
		on = data_oe_n;
		host_rd_n = 1'b1;
		channel_select_n = 2'h3;
		@(negedge core_clk);
		off = data_oe_n;
	endtask
	// save line format, then open another view
	task automatic view_open(input logic ch, input logic [7:0] v);
		logic on, off;
		rd(ch, 3'h3, saved_fmt, on, off);
		wr(ch, 3'h3, v);
	endtask
	// put the saved line format back
	task automatic view_close(input logic ch);
		wr(ch, 3'h3, saved_fmt);
	endtask
	// ready summary: loopback off, ready enable on, read, restore modem control
	task automatic ready_read(input logic ch, output logic [7:0] d);
		logic [7:0] keep;
		logic on, off;
		rd(ch, 3'h4, keep, on, off);
		wr(ch, 3'h4, 8'h04 | (keep & 8'hEF));
		rd(ch, 3'h7, d, on, off);
		wr(ch, 3'h4, keep);
	endtask
endmodule

// File: bench/tb_uart_extended_register_access.sv
// self-checking bench for the banked uart register access block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_uart_extended_register_access import uart_bank_pkg::*;;
	logic core_clk, rst, ce; // clock, reset, clock enable
	logic [1:0] channel_select_n, tx_ready, rx_ready; // selects and ready levels
	logic [2:0] addr; // offset
	logic host_wr_n, host_rd_n, data_oe_n; // strobes and drive flag
	logic [7:0] data_in, data_out, rdy; // bus data, summary read
	logic [1:0] prescale_div4; // prescaler selects
	chan_cfg_t cfg_a, cfg_b; // register copies
	int fail_count = 0; // mismatches
	int cmp_count = 0; // comparisons
	uart_register_bank DUT (.core_clk(core_clk), .rst(rst), .ce(ce), .channel_select_n(channel_select_n),
		.addr(addr), .host_wr_n(host_wr_n), .host_rd_n(host_rd_n), .data_in(data_in), .tx_ready(tx_ready),
		.rx_ready(rx_ready), .data_out(data_out), .data_oe_n(data_oe_n), .prescale_div4(prescale_div4),
		.cfg_a(cfg_a), .cfg_b(cfg_b));
	host_model host (.core_clk(core_clk), .data_out(data_out), .data_oe_n(data_oe_n),
		.channel_select_n(channel_select_n), .addr(addr), .host_wr_n(host_wr_n), .host_rd_n(host_rd_n),
		.data_in(data_in));
	// 200 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// read with data and drive-flag checks
	task automatic rd_chk(input logic ch, input logic [2:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic on, off;
		host.rd(ch, a, d, on, off);
		`CHK("read data", e, d)
		`CHK("drive during read", 1'b0, on)
		`CHK("drive after read", 1'b1, off)
	endtask
	// counts, verdict, end of run
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (5000) @(posedge core_clk);
		fail_count++;
		print_verdict();
	end
	// main sequence
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		tx_ready = 2'h0;
		rx_ready = 2'h0;
		repeat (20) @(negedge core_clk);
		rst = 1'b0;
		`CHK("oe reset", 1'b1, data_oe_n)
		`CHK("prescale reset", 2'h0, prescale_div4)
		`CHK("cfg a reset", CFG_RESET, cfg_a)
		// divisor view
		host.view_open(0, LINE_FMT_DIV_VIEW);
		host.wr(0, OFS_DIV_LOW, 8'h5A);
		host.wr(0, OFS_DIV_HIGH, 8'hC3);
		rd_chk(0, OFS_DIV_LOW, 8'h5A);
		rd_chk(0, OFS_DIV_HIGH, 8'hC3);
		host.view_close(0);
		rd_chk(0, OFS_DIV_HIGH, 8'h00);
		// locked enable and fifo control bits while feature enable clear
		host.wr(0, OFS_DIV_HIGH, 8'hFF);
		rd_chk(0, OFS_DIV_HIGH, 8'h0F);
		host.wr(0, OFS_EXT_FEAT, 8'hFF);
		`CHK("fifo control locked", 8'hCF, cfg_a.fifo_ctl)
		host.wr(0, OFS_STOP_ONE, 8'h2A);
		`CHK("levels refused no feature", 8'h00, cfg_a.halt_resume)
		// locked modem bits while feature enable clear
		host.wr(0, OFS_RESUME_ONE, 8'hFF);
		rd_chk(0, OFS_RESUME_ONE, 8'h1F);
		`CHK("prescale locked", 2'h0, prescale_div4)
		// enhanced view
		host.view_open(0, LINE_FMT_ENH_VIEW);
		host.wr(0, OFS_EXT_FEAT, 8'h1A);
		for (int i = 4; i < 8; i++) begin
			host.wr(0, 3'(i), 8'hA0 + 8'(i));
		end
		rd_chk(0, OFS_EXT_FEAT, 8'h1A);
		for (int i = 4; i < 8; i++) begin
			rd_chk(0, 3'(i), 8'hA0 + 8'(i));
		end
		host.view_close(0);
		`CHK("resume two", 8'hA5, cfg_a.resume_two)
		`CHK("stop one", 8'hA6, cfg_a.stop_one)
		`CHK("feature", 8'h1A, cfg_a.ext_feat)
		// levels refused without modem bit 6
		host.wr(0, OFS_STOP_ONE, 8'h2A);
		`CHK("levels refused", 8'h00, cfg_a.halt_resume)
		host.wr(0, OFS_RESUME_ONE, 8'hC0);
		`CHK("prescale on", 2'h1, prescale_div4)
		rd_chk(0, OFS_RESUME_ONE, 8'hC0);
		host.wr(0, OFS_STOP_ONE, 8'h2A);
		host.wr(0, OFS_STOP_TWO, 8'h31);
		rd_chk(0, OFS_STOP_ONE, 8'h2A);
		rd_chk(0, OFS_STOP_TWO, 8'h31);
		`CHK("levels", 8'h2A, cfg_a.halt_resume)
		// ready summary
		tx_ready = 2'h1;
		rx_ready = 2'h2;
		host.ready_read(0, rdy);
		`CHK("summary 21", 8'h21, rdy)
		tx_ready = 2'h3;
		rx_ready = 2'h3;
		host.ready_read(0, rdy);
		`CHK("summary 33", 8'h33, rdy)
		tx_ready = 2'h0;
		rx_ready = 2'h1;
		host.ready_read(0, rdy);
		`CHK("summary 10", 8'h10, rdy)
		host.wr(0, OFS_RESUME_ONE, 8'hC4);
		host.wr(0, OFS_STOP_TWO, 8'h55);
		`CHK("summary read only", 8'h31, cfg_a.trig_levels)
		host.wr(0, OFS_RESUME_ONE, 8'hD4);
		rd_chk(0, OFS_STOP_TWO, 8'h31);
		host.wr(0, OFS_RESUME_ONE, 8'h40);
		`CHK("prescale off", 2'h0, prescale_div4)
		// sleep blocks divisor writes
		host.wr(0, OFS_DIV_HIGH, 8'h10);
		host.view_open(0, LINE_FMT_DIV_VIEW);
		host.wr(0, OFS_DIV_LOW, 8'h11);
		rd_chk(0, OFS_DIV_LOW, 8'h5A);
		host.view_close(0);
		// clock enable low: a whole write strobe is lost
		ce = 1'b0;
		host.wr(0, OFS_LINE_FMT, 8'h3C);
		ce = 1'b1;
		`CHK("frozen write", 8'h00, cfg_a.line_fmt)
		// channel B separate
		host.wr(1, OFS_LINE_FMT, 8'h80);
		host.wr(1, OFS_DIV_LOW, 8'h77);
		`CHK("b divisor", 8'h77, cfg_b.div_low)
		`CHK("a divisor", 8'h5A, cfg_a.div_low)
		print_verdict();
	end
endmodule

// File: rtl/uart_bank_pkg.sv
// constants, types and helpers shared by the banked uart register access logic
package uart_bank_pkg;

	// register offsets on the 3-bit host address
	localparam logic [2:0] OFS_DIV_LOW = 3'h0; // divisor low byte in divisor view
	localparam logic [2:0] OFS_DIV_HIGH = 3'h1; // divisor high byte / interrupt enable
	localparam logic [2:0] OFS_EXT_FEAT = 3'h2; // feature enable / fifo control
	localparam logic [2:0] OFS_LINE_FMT = 3'h3; // line format, reachable in every view
	localparam logic [2:0] OFS_RESUME_ONE = 3'h4; // resume char one / modem control
	localparam logic [2:0] OFS_RESUME_TWO = 3'h5; // resume char two
	localparam logic [2:0] OFS_STOP_ONE = 3'h6; // stop char one / halt-resume levels
	localparam logic [2:0] OFS_STOP_TWO = 3'h7; // stop char two / trigger levels / ready summary

	// line format values that open the alternate views
	localparam logic [7:0] LINE_FMT_DIV_VIEW = 8'h80;
	localparam logic [7:0] LINE_FMT_ENH_VIEW = 8'hBF;

	// field positions
	localparam int EXT_ENH_BIT = 4; // enhanced functions write enable
	localparam int MODEM_RDY_EN_BIT = 2; // ready summary enable
	localparam int MODEM_LOOP_BIT = 4; // loopback
	localparam int MODEM_THR_BIT = 6; // threshold register access
	localparam int MODEM_PRESCALE_BIT = 7; // divide-by-four prescaler
	localparam int INT_SLEEP_BIT = 4; // sleep mode enable

	// bits that only change while enhanced functions are enabled
	localparam logic [7:0] INT_ENH_MASK = 8'hF0;
	localparam logic [7:0] FIFO_ENH_MASK = 8'h30;
	localparam logic [7:0] MODEM_ENH_MASK = 8'hE0;

	// unused ready summary bit pairs read as zero
	localparam logic [1:0] RDY_PAD = 2'h0;

	// one channel's register set
	typedef struct packed {
		logic [7:0] div_low;
		logic [7:0] div_high;
		logic [7:0] int_enable;
		logic [7:0] fifo_ctl;
		logic [7:0] line_fmt;
		logic [7:0] ext_feat;
		logic [7:0] modem_ctl;
		logic [7:0] resume_one;
		logic [7:0] resume_two;
		logic [7:0] stop_one;
		logic [7:0] stop_two;
		logic [7:0] halt_resume;
		logic [7:0] trig_levels;
	} chan_cfg_t;

	localparam chan_cfg_t CFG_RESET = '0; // every register clears on reset

	// which register a host access reaches
	typedef enum logic [3:0] {
		SEL_NONE, SEL_DIV_LOW, SEL_DIV_HIGH, SEL_INT_EN, SEL_FIFO_CTL, SEL_LINE_FMT,
		SEL_EXT_FEAT, SEL_MODEM, SEL_RESUME_ONE, SEL_RESUME_TWO, SEL_STOP_ONE,
		SEL_STOP_TWO, SEL_HALT_RESUME, SEL_TRIG, SEL_RDY
	} reg_sel_t;

	// write that keeps the protected bits unless enhanced functions are on
	function automatic logic [7:0] guarded_write(input logic [7:0] old_val, input logic [7:0] new_val,
		input logic [7:0] mask, input logic allow);
		guarded_write = allow ? new_val : ((old_val & mask) | (new_val & ~mask));
	endfunction

endpackage

// File: rtl/uart_register_bank.sv
// banked register file and host bus access for both uart channels
//
// How it works
// (RULE_01) ready bit 5 is channel B receive ready
// (RULE_02) ready summary: read-only, offset 7, enabled, no loopback
// (RULE_03) line format 80 maps divisor bytes at 0,1
// (RULE_04) line format BF maps resume/stop chars 4-7
// (RULE_05) line format BF maps feature enable at 2
// (RULE_06) offset 6 is halt/resume levels when enabled
// (RULE_07) offset 7 is trigger levels when enabled
// (RULE_08) host sets ready-enable, clears loopback, reads 7
// (RULE_09) modem bit 7 selects divide-by-four prescaler
// (RULE_10) host saves and restores line format
// (RULE_11) halt/resume levels written only when both enables set
// (RULE_12) enhanced bits locked while feature enable clear
// (RULE_13) divisor written only outside sleep mode
// (RULE_14) view decode is combinational on current registers
`timescale 1ns/1ps
module uart_register_bank import uart_bank_pkg::*; (
	input wire logic core_clk, // uart input clock
	input wire logic rst, // asynchronous reset, active high
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic [1:0] channel_select_n, // bit 0 channel A, bit 1 channel B, active low
	input wire logic [2:0] addr, // host register address
	input wire logic host_wr_n, // host write strobe, active low
	input wire logic host_rd_n, // host read strobe, active low
	input wire logic [7:0] data_in, // host write data
	input wire logic [1:0] tx_ready, // per channel: transmit space at trigger level
	input wire logic [1:0] rx_ready, // per channel: receive above trigger or timeout
	output logic [7:0] data_out, // host read data
	output logic data_oe_n, // low while driving read data
	output logic [1:0] prescale_div4, // per channel prescaler select
	output chan_cfg_t cfg_a, // channel A registers
	output chan_cfg_t cfg_b // channel B registers
);

	chan_cfg_t cfg_ff [2]; // register sets, index 0 is channel A
	logic wr_prev_ff; // write strobe one cycle ago
	logic [7:0] rd_data_ff; // captured read value
	logic oe_n_ff; // read drive enable, active low

	logic cs_any; // either channel selected
	logic chan; // channel addressed, A wins when both selected
	chan_cfg_t cur; // addressed channel's registers
	reg_sel_t sel; // decoded register
	logic wr_fire; // one write per strobe
	logic rd_active; // read in progress this cycle
	logic enh_on; // enhanced writes allowed on addressed channel
	logic [7:0] rd_value; // read mux output

	// channel steering
	always_comb begin
		cs_any = !channel_select_n[0] || !channel_select_n[1]; // RULE_02
		chan = channel_select_n[0];
		cur = cfg_ff[chan];
		enh_on = cur.ext_feat[EXT_ENH_BIT];
		wr_fire = ce && cs_any && !host_wr_n && wr_prev_ff;
		rd_active = ce && cs_any && !host_rd_n;
	end

	// view decode for the addressed channel
	view_select u_view (
		.addr(addr),
		.cfg(cur),
		.sel(sel)
	);

	// write strobe edge history
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_prev_ff <= 1'b1;
		end else if (ce) begin
			wr_prev_ff <= host_wr_n;
		end
	end

	// register writes, one per write strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_ff[0] <= CFG_RESET;
			cfg_ff[1] <= CFG_RESET;
		end else if (wr_fire) begin
			case (sel)
				SEL_DIV_LOW: begin
					// divisor frozen once sleep mode is on
					if (!cur.int_enable[INT_SLEEP_BIT]) cfg_ff[chan].div_low <= data_in; // RULE_13
				end
				SEL_DIV_HIGH: begin
					if (!cur.int_enable[INT_SLEEP_BIT]) cfg_ff[chan].div_high <= data_in; // RULE_13
				end
				SEL_INT_EN: begin
					cfg_ff[chan].int_enable <= guarded_write(cur.int_enable, data_in, INT_ENH_MASK, enh_on); // RULE_12
				end
				SEL_FIFO_CTL: begin
					cfg_ff[chan].fifo_ctl <= guarded_write(cur.fifo_ctl, data_in, FIFO_ENH_MASK, enh_on); // RULE_12
				end
				SEL_MODEM: begin
					// prescaler bit sits among the protected bits
					cfg_ff[chan].modem_ctl <= guarded_write(cur.modem_ctl, data_in, MODEM_ENH_MASK, enh_on); // RULE_09
				end
				SEL_LINE_FMT: cfg_ff[chan].line_fmt <= data_in;
				SEL_EXT_FEAT: cfg_ff[chan].ext_feat <= data_in; // RULE_05
				SEL_RESUME_ONE: cfg_ff[chan].resume_one <= data_in; // RULE_04
				SEL_RESUME_TWO: cfg_ff[chan].resume_two <= data_in; // RULE_04
				SEL_STOP_ONE: cfg_ff[chan].stop_one <= data_in; // RULE_04
				SEL_STOP_TWO: cfg_ff[chan].stop_two <= data_in; // RULE_04
				SEL_HALT_RESUME: cfg_ff[chan].halt_resume <= data_in; // RULE_11
				SEL_TRIG: cfg_ff[chan].trig_levels <= data_in; // RULE_07
				default: begin
					// ready summary and unmapped offsets ignore writes
				end
			endcase
		end
	end

	// read mux
	always_comb begin
		case (sel)
			SEL_DIV_LOW: rd_value = cur.div_low;
			SEL_DIV_HIGH: rd_value = cur.div_high;
			SEL_INT_EN: rd_value = cur.int_enable;
			SEL_LINE_FMT: rd_value = cur.line_fmt;
			SEL_EXT_FEAT: rd_value = cur.ext_feat;
			SEL_MODEM: rd_value = cur.modem_ctl;
			SEL_RESUME_ONE: rd_value = cur.resume_one;
			SEL_RESUME_TWO: rd_value = cur.resume_two;
			SEL_STOP_ONE: rd_value = cur.stop_one;
			SEL_STOP_TWO: rd_value = cur.stop_two;
			SEL_HALT_RESUME: rd_value = cur.halt_resume;
			SEL_TRIG: rd_value = cur.trig_levels;
			SEL_RDY: rd_value = {RDY_PAD, rx_ready, RDY_PAD, tx_ready}; // RULE_01
			default: rd_value = 8'h00; // fifo control is write only here
		endcase
	end

	// read data capture and drive enable
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rd_data_ff <= 8'h00;
			oe_n_ff <= 1'b1;
		end else if (ce) begin
			oe_n_ff <= !rd_active;
			if (rd_active) rd_data_ff <= rd_value;
		end
	end

	// outputs straight from flops
	assign data_out = rd_data_ff;
	assign data_oe_n = oe_n_ff;
	assign prescale_div4 = {cfg_ff[1].modem_ctl[MODEM_PRESCALE_BIT], cfg_ff[0].modem_ctl[MODEM_PRESCALE_BIT]}; // RULE_09
	assign cfg_a = cfg_ff[0];
	assign cfg_b = cfg_ff[1];

	// checks
	logic [207:0] cfg_all; // both register sets, for stability checks
	assign cfg_all = {cfg_ff[1], cfg_ff[0]};

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// a write strobe at an offset in a given line format view
	sequence s_wr(logic [2:0] a, logic [7:0] fmt);
		wr_fire && addr == a && cur.line_fmt == fmt;
	endsequence

	// threshold view open with a normal line format
	sequence s_thr_wr(logic [2:0] a);
		wr_fire && addr == a && cur.line_fmt != LINE_FMT_ENH_VIEW && cur.line_fmt != LINE_FMT_DIV_VIEW
			&& cur.ext_feat[EXT_ENH_BIT] && cur.modem_ctl[MODEM_THR_BIT]
			&& !(a == OFS_STOP_TWO && cur.modem_ctl[MODEM_RDY_EN_BIT] && !cur.modem_ctl[MODEM_LOOP_BIT]);
	endsequence

	property p_rdy_bits;
		(rd_active && sel == SEL_RDY) |=> (rd_data_ff[5] == $past(rx_ready[1]) && rd_data_ff[7:6] == 2'h0 && !oe_n_ff);
	endproperty
	a_rdy_bits: assert property (p_rdy_bits) else $error("ready bit 5 or top bits wrong"); // RULE_01

	property p_rdy_access;
		(rd_active && addr == OFS_STOP_TWO && cur.line_fmt == 8'h00 && cur.modem_ctl[MODEM_RDY_EN_BIT]
			&& !cur.modem_ctl[MODEM_LOOP_BIT]) |=> rd_data_ff == {2'h0, $past(rx_ready), 2'h0, $past(tx_ready)};
	endproperty
	a_rdy_access: assert property (p_rdy_access) else $error("ready summary not returned at offset 7"); // RULE_02

	property p_rdy_ro;
		(wr_fire && sel == SEL_RDY) |=> $stable(cfg_all);
	endproperty
	a_rdy_ro: assert property (p_rdy_ro) else $error("write changed registers through ready summary"); // RULE_02

	property p_div_low;
		(s_wr(OFS_DIV_LOW, LINE_FMT_DIV_VIEW) and !cur.int_enable[INT_SLEEP_BIT])
			|=> cfg_ff[$past(chan)].div_low == $past(data_in);
	endproperty
	a_div_low: assert property (p_div_low) else $error("divisor low byte not written"); // RULE_03

	property p_resume_one;
		s_wr(OFS_RESUME_ONE, LINE_FMT_ENH_VIEW) |=> cfg_ff[$past(chan)].resume_one == $past(data_in)
			&& cfg_ff[$past(chan)].modem_ctl == $past(cur.modem_ctl);
	endproperty
	a_resume_one: assert property (p_resume_one) else $error("resume char one write misrouted"); // RULE_04

	property p_ext_feat;
		s_wr(OFS_EXT_FEAT, LINE_FMT_ENH_VIEW) |=> cfg_ff[$past(chan)].ext_feat == $past(data_in);
	endproperty
	a_ext_feat: assert property (p_ext_feat) else $error("feature enable not written"); // RULE_05

	property p_halt_resume;
		s_thr_wr(OFS_STOP_ONE) |=> cfg_ff[$past(chan)].halt_resume == $past(data_in);
	endproperty
	a_halt_resume: assert property (p_halt_resume) else $error("halt/resume levels not written"); // RULE_06

	property p_trig;
		s_thr_wr(OFS_STOP_TWO) |=> cfg_ff[$past(chan)].trig_levels == $past(data_in);
	endproperty
	a_trig: assert property (p_trig) else $error("trigger levels not written"); // RULE_07

	property p_halt_locked;
		(wr_fire && addr == OFS_STOP_ONE && cur.line_fmt != LINE_FMT_ENH_VIEW
			&& !(cur.ext_feat[EXT_ENH_BIT] && cur.modem_ctl[MODEM_THR_BIT])) |=> $stable(cfg_all);
	endproperty
	a_halt_locked: assert property (p_halt_locked) else $error("levels written without enables"); // RULE_11

	property p_int_locked;
		(wr_fire && sel == SEL_INT_EN && !enh_on) |=> cfg_ff[$past(chan)].int_enable[7:4] == $past(cur.int_enable[7:4]);
	endproperty
	a_int_locked: assert property (p_int_locked) else $error("protected enable bits changed"); // RULE_12

	property p_prescale_locked;
		(wr_fire && sel == SEL_MODEM && !enh_on) |=> $stable(prescale_div4);
	endproperty
	a_prescale_locked: assert property (p_prescale_locked) else $error("prescaler changed while locked"); // RULE_09

	property p_div_sleep;
		(s_wr(OFS_DIV_LOW, LINE_FMT_DIV_VIEW) and cur.int_enable[INT_SLEEP_BIT]) |=> $stable(cfg_all);
	endproperty
	a_div_sleep: assert property (p_div_sleep) else $error("divisor written in sleep mode"); // RULE_13

endmodule

// File: rtl/view_select.sv
// register view decode from address, line format, feature and modem control
`timescale 1ns/1ps
module view_select import uart_bank_pkg::*; (
	input wire logic [2:0] addr, // host address
	input wire chan_cfg_t cfg, // selected channel's registers
	output reg_sel_t sel // register reached
);

	logic div_view; // divisor latch view
	logic enh_view; // enhanced bank view
	logic thr_view; // threshold registers reachable
	logic rdy_view; // ready summary reachable

	// purely combinational, so a view change holds from the next access
	always_comb begin // RULE_14
		div_view = (cfg.line_fmt == LINE_FMT_DIV_VIEW); // RULE_03
		enh_view = (cfg.line_fmt == LINE_FMT_ENH_VIEW); // RULE_04
		thr_view = cfg.ext_feat[EXT_ENH_BIT] && cfg.modem_ctl[MODEM_THR_BIT]; // RULE_06
		rdy_view = cfg.modem_ctl[MODEM_RDY_EN_BIT] && !cfg.modem_ctl[MODEM_LOOP_BIT]; // RULE_02
		sel = SEL_NONE;
		case (addr)
			OFS_DIV_LOW: sel = div_view ? SEL_DIV_LOW : SEL_NONE; // RULE_03
			OFS_DIV_HIGH: sel = div_view ? SEL_DIV_HIGH : SEL_INT_EN; // RULE_03
			OFS_EXT_FEAT: sel = enh_view ? SEL_EXT_FEAT : SEL_FIFO_CTL; // RULE_05
			OFS_LINE_FMT: sel = SEL_LINE_FMT; // RULE_10
			OFS_RESUME_ONE: sel = enh_view ? SEL_RESUME_ONE : SEL_MODEM; // RULE_04
			OFS_RESUME_TWO: sel = enh_view ? SEL_RESUME_TWO : SEL_NONE; // RULE_04
			OFS_STOP_ONE: begin
				// stop char wins in enhanced bank, else threshold levels
				if (enh_view) sel = SEL_STOP_ONE; // RULE_04
				else if (thr_view) sel = SEL_HALT_RESUME; // RULE_06
				else sel = SEL_NONE;
			end
			OFS_STOP_TWO: begin
				// ready summary takes priority over trigger levels
				if (enh_view) sel = SEL_STOP_TWO; // RULE_04
				else if (rdy_view) sel = SEL_RDY; // RULE_02
				else if (thr_view) sel = SEL_TRIG; // RULE_07
				else sel = SEL_NONE;
			end
			default: sel = SEL_NONE;
		endcase
	end

endmodule
